// file: src/sflg_pkg.sv
// Purpose: Constants for the serial status flag and bit rate block.
// Assumes: 32-bit AXI4-Lite register bus, aclk at 50 MHz.
// Notes:   Each register takes one aligned word; data sits in bits 7:0.
`default_nettype none
package sflg_pkg;
	// Register byte addresses
	localparam logic [4:0] SFLG_ADDR_STATUS  = 5'h00; // serial_status_flags
	localparam logic [4:0] SFLG_ADDR_BITRATE = 5'h04; // bit_rate_divisor
	localparam logic [4:0] SFLG_ADDR_CONTROL = 5'h08; // mode and enable bits
	localparam logic [4:0] SFLG_ADDR_RXDATA  = 5'h0C; // receive_data_register
	localparam logic [4:0] SFLG_ADDR_TXDATA  = 5'h10; // transmit_data_register
	// Status register bit positions
	localparam int SFLG_ST_TXEMPTY = 7;
	localparam int SFLG_ST_RXFULL  = 6;
	localparam int SFLG_ST_OVERRUN = 5;
	localparam int SFLG_ST_FRAMING = 4;
	localparam int SFLG_ST_PARITY  = 3;
	localparam int SFLG_ST_TXEND   = 2;
	localparam int SFLG_ST_MPRX    = 1;
	localparam int SFLG_ST_MPTX    = 0;
	// Control register bit positions
	localparam int SFLG_CT_RXEN    = 0;
	localparam int SFLG_CT_TXEN    = 1;
	localparam int SFLG_CT_SYNC    = 2;
	localparam int SFLG_CT_MPEN    = 3;
	localparam int SFLG_CT_ODD     = 4;
	localparam int SFLG_CT_PSLO    = 5;
	localparam int SFLG_CT_PSHI    = 6;
	// Reset values
	localparam logic [7:0] SFLG_STATUS_RST  = 8'h84;
	localparam logic [7:0] SFLG_BITRATE_RST = 8'hFF;
	localparam logic [7:0] SFLG_CONTROL_RST = 8'h00;
	// Prescaler terminal counts (ratio minus one) for selects 00..11
	localparam logic [5:0] SFLG_PS_DIV1  = 6'h00;
	localparam logic [5:0] SFLG_PS_DIV4  = 6'h03;
	localparam logic [5:0] SFLG_PS_DIV16 = 6'h0F;
	localparam logic [5:0] SFLG_PS_DIV64 = 6'h3F;
	// Rate ticks per bit: 64 asynchronous, 8 synchronous; 4 per 16x sample
	localparam logic [5:0] SFLG_ASYNC_BIT_LAST = 6'h3F;
	localparam logic [5:0] SFLG_SYNC_BIT_LAST  = 6'h07;
	localparam logic [1:0] SFLG_SAMPLE_LAST    = 2'h3;
	// Bus responses
	localparam logic [1:0] SFLG_RESP_OKAY   = 2'h0;
	localparam logic [1:0] SFLG_RESP_SLVERR = 2'h2;
endpackage : sflg_pkg
`default_nettype wire

// file: src/sflg_serial_flags.sv
// Purpose: Status flags, multiprocessor bits and bit rate generator of a serial unit.
// Assumes: Frame shifters sit outside on aclk and report character events as pulses.
// Notes:   Registers reached over AXI4-Lite; low-power entry acts like reset on flags.
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`default_nettype none

module sflg_serial_flags
	import sflg_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Low-power mode entry (standby, watch, subactive, subsleep)
	input  wire logic        lowpower_enter,
	// AXI4-Lite write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	// AXI4-Lite write data
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// AXI4-Lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	// AXI4-Lite read data
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// Receive frame events from the receive shifter
	input  wire logic        rx_char_done,
	input  wire logic [7:0]  rx_char_data,
	input  wire logic        rx_has_parity,
	input  wire logic        rx_parity_bit,
	input  wire logic        rx_first_stop,
	input  wire logic        rx_mp_bit,
	// Transmit frame events from the transmit shifter
	input  wire logic        tx_char_load,
	input  wire logic        tx_last_bit_out,
	// Controls and data toward the shifters
	output logic             rx_halt,
	output logic             tx_halt,
	output logic [7:0]       tx_char_data,
	output logic             tx_mp_bit,
	output logic             tx_mp_bit_used,
	output logic             sample_tick,
	output logic             bit_tick,
	// Error event toward the interrupt logic
	output logic             rx_error_event
);

	// Register state
	logic [7:0] status_q;      // serial_status_flags
	logic [7:0] bitrate_q;     // bit_rate_divisor
	logic [7:0] control_q;     // Mode and enable bits
	logic [7:0] rxdata_q;      // receive_data_register
	logic [7:0] txdata_q;      // transmit_data_register
	logic [7:3] armed_q;       // Flag was read as one since last clear
	logic       error_event_q; // One-cycle error pulse

	// Bus channel state
	logic        aw_held_q;
	logic        w_held_q;
	logic [4:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;

	// Bit rate generator state
	logic [5:0] pscnt_q;   // Prescaler counter
	logic [7:0] divcnt_q;  // Divisor counter
	logic [1:0] smpcnt_q;  // Rate ticks per sample
	logic [5:0] bitcnt_q;  // Rate ticks per bit
	logic       sample_q;
	logic       bit_q;

	// Decoded controls
	logic rx_en, tx_en, sync_mode, mp_en, odd_sel;
	assign rx_en     = control_q[SFLG_CT_RXEN];
	assign tx_en     = control_q[SFLG_CT_TXEN];
	assign sync_mode = control_q[SFLG_CT_SYNC];
	assign mp_en     = control_q[SFLG_CT_MPEN];
	assign odd_sel   = control_q[SFLG_CT_ODD];

	// Bus handshakes; a channel is refused while its word is held or a response waits
	logic       aw_take, w_take, do_write, ar_take;
	logic [4:0] wr_addr;
	logic [7:0] wr_byte;
	logic       wr_lane;
	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready  = !w_held_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take  = s_axi_wvalid && s_axi_wready;
	assign ar_take = s_axi_arvalid && s_axi_arready;
	assign do_write = (aw_held_q || aw_take) && (w_held_q || w_take) && !bvalid_q;
	assign wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
	assign wr_byte = w_held_q ? wdata_q[7:0] : s_axi_wdata[7:0];
	assign wr_lane = w_held_q ? wstrb_q[0] : s_axi_wstrb[0];
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;

	// Write strobes per register; a write without byte lane 0 changes nothing
	logic wr_status, wr_bitrate, wr_control, wr_txdata, wr_mapped;
	logic rd_status, rd_rxdata;
	assign wr_status  = do_write && wr_lane && (wr_addr == SFLG_ADDR_STATUS);
	assign wr_bitrate = do_write && wr_lane && (wr_addr == SFLG_ADDR_BITRATE);
	assign wr_control = do_write && wr_lane && (wr_addr == SFLG_ADDR_CONTROL);
	assign wr_txdata  = do_write && wr_lane && (wr_addr == SFLG_ADDR_TXDATA);
	assign wr_mapped  = (wr_addr == SFLG_ADDR_STATUS) || (wr_addr == SFLG_ADDR_BITRATE) ||
		(wr_addr == SFLG_ADDR_CONTROL) || (wr_addr == SFLG_ADDR_TXDATA) ||
		(wr_addr == SFLG_ADDR_RXDATA);
	assign rd_status  = ar_take && (s_axi_araddr == SFLG_ADDR_STATUS);
	assign rd_rxdata  = ar_take && (s_axi_araddr == SFLG_ADDR_RXDATA);

	// Address and data holding for out-of-order write channels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			awaddr_q  <= 5'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
		end else begin
			// Hold whichever half came first until the other arrives
			if (aw_take && !do_write) begin
				aw_held_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held_q <= 1'b0;
			end
			if (w_take && !do_write) begin
				w_held_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end else if (do_write) begin
				w_held_q <= 1'b0;
			end
		end
	end

	// Write response; unmapped addresses answer SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= SFLG_RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_mapped ? SFLG_RESP_OKAY : SFLG_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Read data path; data is captured at the address handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= SFLG_RESP_OKAY;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
			rresp_q  <= SFLG_RESP_OKAY;
			if (s_axi_araddr == SFLG_ADDR_STATUS) begin
				rdata_q <= {24'h000000, status_q};
			end else if (s_axi_araddr == SFLG_ADDR_BITRATE) begin
				rdata_q <= {24'h000000, bitrate_q};
			end else if (s_axi_araddr == SFLG_ADDR_CONTROL) begin
				rdata_q <= {24'h000000, control_q};
			end else if (s_axi_araddr == SFLG_ADDR_RXDATA) begin
				rdata_q <= {24'h000000, rxdata_q};
			end else if (s_axi_araddr == SFLG_ADDR_TXDATA) begin
				rdata_q <= {24'h000000, txdata_q};
			end else begin
				// Unmapped: zero data with an error answer
				rdata_q <= 32'h0000_0000;
				rresp_q <= SFLG_RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// Control and transmit data registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			control_q <= SFLG_CONTROL_RST;
			txdata_q  <= 8'h00;
		end else begin
			if (wr_control) begin
				control_q <= wr_byte;
			end
			if (wr_txdata) begin
				txdata_q <= wr_byte;
			end
		end
	end

	// Bit rate divisor; writable at any time, all ones on reset or low power
	always_ff @(posedge aclk) begin
		if (!aresetn || lowpower_enter) begin
			bitrate_q <= SFLG_BITRATE_RST;
		end else if (wr_bitrate) begin
			bitrate_q <= wr_byte;
		end
	end

	// Clear requests: a zero written to a flag that was read as one
	logic [7:3] clr_req;
	genvar gi;
	generate
		for (gi = 3; gi <= 7; gi++) begin : g_arm
			assign clr_req[gi] = wr_status && !wr_byte[gi] && armed_q[gi];
			// Arm on a read that saw one; disarm once the flag is zero or the clear is spent,
			// so a later zero write needs a fresh read of one
			always_ff @(posedge aclk) begin
				if (!aresetn || lowpower_enter) begin
					armed_q[gi] <= 1'b0;
				end else if (rd_status && status_q[gi]) begin
					armed_q[gi] <= 1'b1;
				end else if (!status_q[gi] || clr_req[gi]) begin
					armed_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// Receive character checks
	logic any_error, rx_accept, framing_bad, parity_bad, overrun, rx_clean;
	assign any_error   = status_q[SFLG_ST_OVERRUN] || status_q[SFLG_ST_FRAMING] ||
		status_q[SFLG_ST_PARITY];
	// Errors and disabled receiver both ignore completed characters
	assign rx_accept   = rx_char_done && rx_en && !any_error;
	// The shifter reports only the first stop bit; a second one never reaches here
	assign framing_bad = !sync_mode && !rx_first_stop;
	// Even setting wants an even count of ones, odd setting an odd count
	assign parity_bad  = !sync_mode && rx_has_parity &&
		((^rx_char_data ^ rx_parity_bit) != odd_sel);
	assign overrun     = rx_accept && status_q[SFLG_ST_RXFULL];
	assign rx_clean    = rx_accept && !overrun && !framing_bad && !parity_bad;

	// Receive data register; an overrun leaves the older character in place
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rxdata_q <= 8'h00;
		end else if (rx_accept && !overrun) begin
			rxdata_q <= rx_char_data;
		end
	end

	// Receive error flags; hardware set wins over software clear
	logic set_oer, set_fer, set_per;
	assign set_oer = overrun;
	assign set_fer = rx_accept && !overrun && framing_bad;
	assign set_per = rx_accept && !overrun && parity_bad;
	always_ff @(posedge aclk) begin
		if (!aresetn || lowpower_enter) begin
			status_q[SFLG_ST_OVERRUN] <= SFLG_STATUS_RST[SFLG_ST_OVERRUN];
			status_q[SFLG_ST_FRAMING] <= SFLG_STATUS_RST[SFLG_ST_FRAMING];
			status_q[SFLG_ST_PARITY]  <= SFLG_STATUS_RST[SFLG_ST_PARITY];
		end else begin
			// Receive enable plays no part here, so clearing it keeps the flags
			if (set_oer) begin
				status_q[SFLG_ST_OVERRUN] <= 1'b1;
			end else if (clr_req[SFLG_ST_OVERRUN]) begin
				status_q[SFLG_ST_OVERRUN] <= 1'b0;
			end
			if (set_fer) begin
				status_q[SFLG_ST_FRAMING] <= 1'b1;
			end else if (clr_req[SFLG_ST_FRAMING]) begin
				status_q[SFLG_ST_FRAMING] <= 1'b0;
			end
			if (set_per) begin
				status_q[SFLG_ST_PARITY] <= 1'b1;
			end else if (clr_req[SFLG_ST_PARITY]) begin
				status_q[SFLG_ST_PARITY] <= 1'b0;
			end
		end
	end

	// Receive full flag; only a clean character sets it
	always_ff @(posedge aclk) begin
		if (!aresetn || lowpower_enter) begin
			status_q[SFLG_ST_RXFULL] <= SFLG_STATUS_RST[SFLG_ST_RXFULL];
		end else if (rx_clean) begin
			status_q[SFLG_ST_RXFULL] <= 1'b1;
		end else if (clr_req[SFLG_ST_RXFULL] || rd_rxdata) begin
			status_q[SFLG_ST_RXFULL] <= 1'b0;
		end
	end

	// Transmit empty and transmit end flags
	logic transmit_empty_flag_clear;
	assign transmit_empty_flag_clear = clr_req[SFLG_ST_TXEMPTY] || wr_txdata;
	always_ff @(posedge aclk) begin
		if (!aresetn || lowpower_enter) begin
			status_q[SFLG_ST_TXEMPTY] <= SFLG_STATUS_RST[SFLG_ST_TXEMPTY];
			status_q[SFLG_ST_TXEND]   <= SFLG_STATUS_RST[SFLG_ST_TXEND];
		end else begin
			if (!tx_en || tx_char_load) begin
				status_q[SFLG_ST_TXEMPTY] <= 1'b1;
			end else if (transmit_empty_flag_clear) begin
				status_q[SFLG_ST_TXEMPTY] <= 1'b0;
			end
			// Bus writes clear this bit only through transmit_empty_flag_clear; set wins over clear
			if (!tx_en || (tx_last_bit_out && status_q[SFLG_ST_TXEMPTY])) begin
				status_q[SFLG_ST_TXEND] <= 1'b1;
			end else if (transmit_empty_flag_clear) begin
				status_q[SFLG_ST_TXEND] <= 1'b0;
			end
		end
	end

	// Multiprocessor bits; received bit is read-only, transmit bit is writable
	always_ff @(posedge aclk) begin
		if (!aresetn || lowpower_enter) begin
			status_q[SFLG_ST_MPRX] <= SFLG_STATUS_RST[SFLG_ST_MPRX];
			status_q[SFLG_ST_MPTX] <= SFLG_STATUS_RST[SFLG_ST_MPTX];
		end else begin
			// Disabled receiver accepts nothing, so the bit holds
			if (rx_accept && !overrun && mp_en && !sync_mode) begin
				status_q[SFLG_ST_MPRX] <= rx_mp_bit;
			end
			if (wr_status) begin
				status_q[SFLG_ST_MPTX] <= wr_byte[SFLG_ST_MPTX];
			end
		end
	end

	// Transmit multiprocessor bit reaches the shifter only in async multiprocessor use
	assign tx_mp_bit_used = tx_en && mp_en && !sync_mode;
	assign tx_mp_bit      = tx_mp_bit_used && status_q[SFLG_ST_MPTX];
	assign tx_char_data   = txdata_q;

	// Halts toward the shifters
	assign rx_halt = any_error;
	assign tx_halt = any_error && sync_mode;

	// Error event pulse, one cycle per character that sets any error flag
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			error_event_q <= 1'b0;
		end else begin
			error_event_q <= set_oer || set_fer || set_per;
		end
	end
	assign rx_error_event = error_event_q;

	// Prescaler: terminal count chosen by the two select bits
	logic [5:0] ps_last;
	logic       ps_tick, div_tick;
	always_comb begin
		case ({control_q[SFLG_CT_PSHI], control_q[SFLG_CT_PSLO]})
			2'h0: ps_last = SFLG_PS_DIV1;
			2'h1: ps_last = SFLG_PS_DIV4;
			2'h2: ps_last = SFLG_PS_DIV16;
			default: ps_last = SFLG_PS_DIV64;
		endcase
	end
	assign ps_tick  = (pscnt_q >= ps_last);
	assign div_tick = ps_tick && (divcnt_q >= bitrate_q);

	// Counter chain: prescaler, divisor (N+1 ticks), then sample and bit dividers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pscnt_q  <= 6'h00;
			divcnt_q <= 8'h00;
			smpcnt_q <= 2'h0;
			bitcnt_q <= 6'h00;
			sample_q <= 1'b0;
			bit_q    <= 1'b0;
		end else begin
			pscnt_q  <= ps_tick ? 6'h00 : pscnt_q + 6'h01;
			sample_q <= 1'b0;
			bit_q    <= 1'b0;
			if (ps_tick) begin
				divcnt_q <= div_tick ? 8'h00 : divcnt_q + 8'h01;
			end
			if (div_tick) begin
				smpcnt_q <= smpcnt_q + 2'h1;
				sample_q <= (smpcnt_q == SFLG_SAMPLE_LAST);
				// Async bit: 64 rate ticks; sync bit: 8 rate ticks
				if (bitcnt_q >= (sync_mode ? SFLG_SYNC_BIT_LAST : SFLG_ASYNC_BIT_LAST)) begin
					bitcnt_q <= 6'h00;
					bit_q    <= 1'b1;
				end else begin
					bitcnt_q <= bitcnt_q + 6'h01;
				end
			end
		end
	end
	assign sample_tick = sample_q;
	assign bit_tick    = bit_q;

	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_overrun_keeps_data: assert property (
		overrun |=> (rxdata_q == $past(rxdata_q)) && status_q[SFLG_ST_OVERRUN])
		else $error("overrun changed receive data");
	a_error_halts_rx: assert property (
		(any_error && rx_char_done) |=> $stable(rxdata_q) && $stable(status_q[SFLG_ST_RXFULL] ) ||
		$fell(status_q[SFLG_ST_RXFULL]))
		else $error("character accepted while error set");
	a_framing_sets: assert property (
		(rx_accept && !overrun && !sync_mode && !rx_first_stop) |=> status_q[SFLG_ST_FRAMING])
		else $error("framing error not flagged");
	a_bad_no_full: assert property (
		(rx_accept && !status_q[SFLG_ST_RXFULL] && (framing_bad || parity_bad))
		|=> !status_q[SFLG_ST_RXFULL] && (rxdata_q == $past(rx_char_data)))
		else $error("bad character set full flag");
	a_write_one_holds: assert property (
		(wr_status && wr_byte[SFLG_ST_FRAMING] && status_q[SFLG_ST_FRAMING] && !lowpower_enter)
		|=> status_q[SFLG_ST_FRAMING])
		else $error("write of one cleared framing flag");
	a_txend_clear: assert property (
		(wr_txdata && tx_en && !tx_last_bit_out && !lowpower_enter) |=> !status_q[SFLG_ST_TXEND])
		else $error("transmit end not cleared by data write");
	a_txend_disable: assert property (
		!tx_en |=> status_q[SFLG_ST_TXEND] && status_q[SFLG_ST_TXEMPTY])
		else $error("transmit end not set while disabled");
	a_mprx_holds: assert property (
		(!rx_en && !lowpower_enter) |=> $stable(status_q[SFLG_ST_MPRX]))
		else $error("received multiprocessor bit changed while disabled");
	a_bitrate_reset: assert property (
		lowpower_enter |=> (bitrate_q == SFLG_BITRATE_RST) && (status_q == SFLG_STATUS_RST))
		else $error("low power entry did not restore registers");
	a_error_event: assert property (
		$rose(status_q[SFLG_ST_PARITY]) |-> rx_error_event)
		else $error("parity setting without event");

endmodule : sflg_serial_flags
`default_nettype wire

// file: bench/sflg_station.sv
// Purpose: Stand-in for the frame shifters and the remote station behind them.
// Assumes: Bench calls one task at a time; all changes follow a rising aclk edge.
// Notes:   Idle frame lines show the inverse of the last character, never a stale copy.
`default_nettype none
module sflg_station (
	// Clock
	input  wire logic       aclk,
	// Receive frame events
	output logic            rx_char_done,
	output logic [7:0]      rx_char_data,
	output logic            rx_has_parity,
	output logic            rx_parity_bit,
	output logic            rx_first_stop,
	output logic            rx_mp_bit,
	// Transmit frame events
	output logic            tx_char_load,
	output logic            tx_last_bit_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// Quiet lines at start
	initial begin
		{rx_char_done, tx_char_load, tx_last_bit_out} = 3'h0;
		{rx_char_data, rx_has_parity, rx_parity_bit, rx_first_stop, rx_mp_bit} = 12'h0FF;
	end
	// One finished character; a second stop bit is never reported
	task automatic send(input logic [7:0] d, input logic hp, p, st, mp);
		@(posedge aclk);
		rx_char_done <= 1'b1;
		{rx_char_data, rx_has_parity, rx_parity_bit, rx_first_stop, rx_mp_bit} <= {d, hp, p, st, mp};
		@(posedge aclk);
		rx_char_done <= 1'b0;
		{rx_char_data, rx_has_parity, rx_parity_bit, rx_first_stop, rx_mp_bit} <= ~{d, hp, p, st, mp};
	endtask : send
	// Shifter takes the transmit data, or its last bit leaves the line
	task automatic tx_event(input logic last);
		@(posedge aclk);
		tx_char_load    <= ~last;
		tx_last_bit_out <= last;
		@(posedge aclk);
		{tx_char_load, tx_last_bit_out} <= 2'h0;
	endtask : tx_event
endmodule : sflg_station
`default_nettype wire

// file: bench/uart_status_flags_and_bit_rate_test.sv
// Purpose: Register-level test of the serial status flags and bit rate block.
// Assumes: AXI4-Lite master tasks and a frame event stand-in, one 50 MHz clock.
// Notes:   Expected values follow the status layout, never the design's outputs.
`default_nettype none
module uart_status_flags_and_bit_rate_test import sflg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// Short register addresses
	localparam logic [4:0] st_a = SFLG_ADDR_STATUS;
	localparam logic [4:0] br_a = SFLG_ADDR_BITRATE;
	localparam logic [4:0] ct_a = SFLG_ADDR_CONTROL;
	localparam logic [4:0] rx_a = SFLG_ADDR_RXDATA;
	localparam logic [4:0] tx_a = SFLG_ADDR_TXDATA;
	// Clock, reset, bus and block signals
	logic        aclk, aresetn, lowpower_enter;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [4:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp, rd_resp, wr_resp;
	logic [3:0]  wstrb;
	logic        rx_halt, tx_halt, tx_mp_bit, tx_mp_bit_used, sample_tick, bit_tick, rx_error_event;
	logic        rx_char_done, rx_has_parity, rx_parity_bit, rx_first_stop, rx_mp_bit;
	logic        tx_char_load, tx_last_bit_out;
	logic [7:0]  rx_char_data, tx_char_data, rd_val;
	int          n_errors, checks_done, parity_error_flag;
	int          n_evt = 0; // Error event pulses seen
	// Block under test; protection tied, no effect expected from it
	sflg_serial_flags u_sflg_serial_flags (.aclk, .aresetn, .lowpower_enter,
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.rx_char_done, .rx_char_data, .rx_has_parity, .rx_parity_bit, .rx_first_stop, .rx_mp_bit,
		.tx_char_load, .tx_last_bit_out, .rx_halt, .tx_halt, .tx_char_data, .tx_mp_bit,
		.tx_mp_bit_used, .sample_tick, .bit_tick, .rx_error_event);
	// Far side stand-in
	sflg_station u_sflg_station (.aclk, .rx_char_done, .rx_char_data, .rx_has_parity,
		.rx_parity_bit, .rx_first_stop, .rx_mp_bit, .tx_char_load, .tx_last_bit_out);
	// 20 ns clock
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	// Count error event pulses, one per character that sets any error flag
	always @(posedge aclk) begin
		if (rx_error_event === 1'b1) n_evt <= n_evt + 1;
	end
	// Counts, verdict and end of run
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results
	// One comparison
	task automatic chk(input string nm, input logic [15:0] exp, got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : chk
	// A bus wait that ran out ends the run
	task automatic tmo(input int i);
		if (i >= 50) begin
			n_errors++;
			$display("mismatch wait expected within bound seen none");
			results();
		end
	endtask : tmo
	// Write: address and data offered together, each released once taken
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		int i;
		@(posedge aclk);
		{awvalid, wvalid, bready, awaddr, wdata} <= {3'h7, a, 24'h000000, d};
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if ((awready || !awvalid) && (wready || !wvalid)) break;
		end
		tmo(i);
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (bvalid) break;
		end
		tmo(i);
		wr_resp = bresp;
		bready <= 1'b0;
	endtask : wr
	// Read: data and response taken at the rvalid edge
	task automatic rd(input logic [4:0] a);
		int i;
		@(posedge aclk);
		{arvalid, rready, araddr} <= {2'h3, a};
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (arready) break;
		end
		tmo(i);
		arvalid <= 1'b0;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (rvalid) break;
		end
		tmo(i);
		{rd_val, rd_resp} = {rdata[7:0], rresp};
		rready <= 1'b0;
	endtask : rd
	// Read and compare one register
	task automatic rchk(input string nm, input logic [4:0] a, input logic [7:0] e);
		rd(a);
		chk(nm, {8'h00, e}, {8'h00, rd_val});
	endtask : rchk
	// Cycles between two pulses of a tick
	task automatic period(input bit b);
		int i;
		for (i = 0; i < 600; i++) begin
			@(posedge aclk);
			if (b ? bit_tick : sample_tick) break;
		end
		if (i >= 600) tmo(50);
		for (parity_error_flag = 1; parity_error_flag < 600; parity_error_flag++) begin
			@(posedge aclk);
			if (b ? bit_tick : sample_tick) break;
		end
	endtask : period
	// Main sequence
	initial begin
		{aresetn, lowpower_enter, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
		{awaddr, araddr, wdata, n_errors, checks_done} = 106'h0;
		wstrb = 4'hF;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rchk("status", st_a, 8'h84);
		rchk("divisor", br_a, 8'hFF);
		wr(br_a, 8'h5A);
		rchk("divisor", br_a, 8'h5A);
		chk("write resp", {14'h0000, SFLG_RESP_OKAY}, {14'h0000, wr_resp});
		wstrb <= 4'hE;
		wr(br_a, 8'h11);
		wstrb <= 4'hF;
		rchk("divisor no lane", br_a, 8'h5A);
		wr(5'h14, 8'h00);
		chk("unmapped write resp", {14'h0000, SFLG_RESP_SLVERR}, {14'h0000, wr_resp});
		rd(5'h14);
		chk("unmapped resp", {14'h0000, SFLG_RESP_SLVERR}, {14'h0000, rd_resp});
		$display("test registers done");
		// Prescale ratios 1, 4, 16, 64 at divisor 0; sample is 4 rate ticks
		wr(br_a, 8'h00);
		for (int s = 0; s < 4; s++) begin
			wr(ct_a, 8'(s << 5));
			period(1'b0);
			chk("sample period", 16'(4 << (2 * s)), 16'(parity_error_flag));
		end
		wr(ct_a, 8'h00);
		wr(br_a, 8'h02);
		period(1'b1);
		chk("bit period", 16'h00C0, 16'(parity_error_flag));
		$display("test rate done");
		// Overrun keeps old data; unarmed zero write has no effect
		wr(ct_a, 8'h01);
		u_sflg_station.send(8'h55, 1'b0, 1'b0, 1'b1, 1'b0);
		u_sflg_station.send(8'hAA, 1'b0, 1'b0, 1'b1, 1'b0);
		@(negedge aclk);
		chk("rx halt", 16'h0001, {15'h0000, rx_halt});
		wr(st_a, 8'h00);
		rchk("status", st_a, 8'hE4);
		wr(st_a, 8'h00);
		rchk("status", st_a, 8'h84);
		rchk("rx data", rx_a, 8'h55);
		$display("test overrun done");
		// Framing error survives receive disable and blocks reception
		u_sflg_station.send(8'h33, 1'b0, 1'b0, 1'b0, 1'b0);
		wr(ct_a, 8'h00);
		rchk("status", st_a, 8'h94);
		wr(ct_a, 8'h01);
		u_sflg_station.send(8'h77, 1'b0, 1'b0, 1'b1, 1'b0);
		rchk("rx data", rx_a, 8'h33);
		wr(st_a, 8'h00);
		$display("test framing done");
		// Parity: even select mismatch, then odd select match
		u_sflg_station.send(8'h01, 1'b1, 1'b0, 1'b1, 1'b0);
		rchk("status", st_a, 8'h8C);
		rchk("rx data", rx_a, 8'h01);
		wr(st_a, 8'h00);
		wr(ct_a, 8'h11);
		u_sflg_station.send(8'h01, 1'b1, 1'b0, 1'b1, 1'b0);
		rchk("status", st_a, 8'hC4);
		rd(rx_a);
		$display("test parity done");
		// Synchronous overrun also halts transmission
		wr(ct_a, 8'h05);
		period(1'b1);
		chk("sync bit period", 16'h0018, 16'(parity_error_flag));
		u_sflg_station.send(8'h01, 1'b0, 1'b0, 1'b1, 1'b0);
		u_sflg_station.send(8'h02, 1'b0, 1'b0, 1'b1, 1'b0);
		@(negedge aclk);
		chk("tx halt", 16'h0001, {15'h0000, tx_halt});
		rd(st_a);
		wr(st_a, 8'h00);
		$display("test sync halt done");
		// Multiprocessor bits
		wr(ct_a, 8'h09);
		u_sflg_station.send(8'h12, 1'b0, 1'b0, 1'b1, 1'b1);
		wr(ct_a, 8'h08);
		wr(st_a, 8'h01);
		rchk("status", st_a, 8'hC7);
		chk("mp bit off", 16'h0000, {15'h0000, tx_mp_bit});
		wr(ct_a, 8'h0A);
		chk("mp bit on", 16'h0001, {15'h0000, tx_mp_bit});
		chk("mp bit used", 16'h0001, {15'h0000, tx_mp_bit_used});
		$display("test multiprocessor done");
		// Transmit end flag: cleared by data write, set by last bit or disable
		wr(tx_a, 8'h3C);
		chk("tx data out", 16'h003C, {8'h00, tx_char_data});
		wr(st_a, 8'h07);
		rchk("status", st_a, 8'h03);
		u_sflg_station.tx_event(1'b0);
		rchk("status", st_a, 8'h83);
		u_sflg_station.tx_event(1'b1);
		rchk("status", st_a, 8'h87);
		wr(tx_a, 8'h5C);
		wr(ct_a, 8'h08);
		rchk("status", st_a, 8'h87);
		$display("test transmit end done");
		// Low-power entry restores divisor and status
		wr(br_a, 8'h12);
		@(posedge aclk);
		lowpower_enter <= 1'b1;
		@(posedge aclk);
		lowpower_enter <= 1'b0;
		rchk("divisor", br_a, 8'hFF);
		rchk("status", st_a, 8'h84);
		$display("test low power done");
		chk("error events", 16'h0004, 16'(n_evt));
		results();
	end
endmodule : uart_status_flags_and_bit_rate_test
`default_nettype wire
